// ==== fsm_pkg.sv ====
// Purpose: shared types and constants for the fieldbus node state machine
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes:   Contract list below
// Contract
// - after reset sit in init; refuse mailbox and process data there
// - init to preop checks mailbox channel configuration first
// - preop allows mailbox but no process data
// - preop to state_alias_a checks process channels and sync clock setup
// - copy current inputs into exchange memory before acknowledging state_alias_a
// - state_alias_a: mailbox and process data, inputs refreshed, outputs held safe
// - monitoring on forces safe outputs; off lets outputs drive in state_alias_a
// - op copies master outputs to physical outputs, all traffic allowed
// - normal startup ends in op as the working state
// - boot reachable only from init
// - boot accepts only file transfer mailbox, no process data
// - dictionary address is 16-bit index and 8-bit subindex
// - ranges 0x1000 identity, 0x8000 channel, 0x6000 in, 0x7000 out
// - legacy 0x4000 channel area mirrors 0x8000
// - access follows entry attribute; fixed entries read-only
// - changed values committed to non-volatile store fail-safe
// - code word 0x12345678 at 0xF008 suppresses saving until changed
package fsm_pkg;
   typedef enum logic [2:0] {
      FSM_INIT, FSM_PREOP, FSM_STATE_ALIAS_A, FSM_OP, FSM_BOOT
   } fsm_state_e;
   localparam logic [15:0] FSM_IDX_IDENT   = 16'h1000;
   localparam logic [15:0] FSM_IDX_LEGACY  = 16'h4000;
   localparam logic [15:0] FSM_IDX_INPUT   = 16'h6000;
   localparam logic [15:0] FSM_IDX_OUTPUT  = 16'h7000;
   localparam logic [15:0] FSM_IDX_CHAN    = 16'h8000;
   localparam logic [15:0] FSM_IDX_NOSTORE = 16'hf008;
   localparam logic [31:0] FSM_NOSTORE_KEY = 32'h12345678;
   localparam logic [3:0]  FSM_AREA_SHIFT  = 4'hc;
   localparam int          FSM_CH_BITS     = 4;
   localparam int          FSM_IO_W        = 16;
   localparam logic [15:0] FSM_SAFE_OUT    = 16'h0000;
   localparam int          FSM_NV_NS       = 100;
   localparam int          FSM_CLK_NS      = 20;
   localparam int          FSM_NV_CYC      = (FSM_NV_NS + FSM_CLK_NS - 1)
                                             / FSM_CLK_NS;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] index;
      logic [7:0]  subindex;
      logic [31:0] wdata;
   } fsm_dict_req_s;
   typedef struct packed {
      logic        valid;
      logic        error;
      logic [31:0] rdata;
   } fsm_dict_rsp_s;
   typedef struct packed {
      logic       mbx_ok;
      logic       pd_ok;
      logic       foe_only;
   } fsm_gate_s;
endpackage : fsm_pkg

// ==== fsm_mem.sv ====
// Purpose: small parameter store, registered read data
// Assumes: one read or write per cycle
// Notes:   address is channel slot and subindex
`timescale 1ns/10ps
`default_nettype none
module fsm_mem (
   input  wire logic        clk,
   input  wire logic        we,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   output logic      [31:0] rdata
);
   logic [31:0] mem [0:4095];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : fsm_mem
`default_nettype wire

// ==== fsm_nvcommit.sv ====
// Purpose: fail-safe commit of changed values to non-volatile store
// Assumes: store write takes a fixed number of cycles
// Notes:   new value latched on the same edge the write starts; busy until done
`timescale 1ns/10ps
`default_nettype none
module fsm_nvcommit (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [23:0] addr,
   input  wire logic [31:0] data,
   output logic             nv_we,
   output logic      [23:0] nv_addr,
   output logic      [31:0] nv_data,
   output logic             busy
);
   typedef struct packed {
      logic        we;
      logic [23:0] addr;
      logic [31:0] data;
      logic [7:0]  cnt;
      logic        busy;
   } fsm_nv_s;
   fsm_nv_s st_reg, st_next;
   always_comb begin
      st_next = st_reg;
      st_next.we = 1'b0;
      if (st_reg.busy) begin
         if (st_reg.cnt == 8'h00) begin
            st_next.busy = 1'b0;
         end else begin
            st_next.cnt = st_reg.cnt - 8'h01;
         end
      end else if (start) begin
         st_next.we   = 1'b1;
         st_next.addr = addr;
         st_next.data = data;
         st_next.busy = 1'b1;
         st_next.cnt  = 8'(fsm_pkg::FSM_NV_CYC);
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign nv_we   = st_reg.we;
   assign nv_addr = st_reg.addr;
   assign nv_data = st_reg.data;
   assign busy    = st_reg.busy;
endmodule : fsm_nvcommit
`default_nettype wire

// ==== fsm_node.sv ====
// Purpose: node state machine with gated traffic and parameter dictionary
// Assumes: master requests states by code; checks arrive as levels
// Notes:   outputs held safe unless op, or state_alias_a with monitoring off
`timescale 1ns/10ps
`default_nettype none
module fsm_node (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  req_valid,
   input  wire fsm_pkg::fsm_state_e   req_state,
   input  wire logic                  mbx_cfg_ok,
   input  wire logic                  pd_cfg_ok,
   input  wire logic                  dc_used,
   input  wire logic                  dc_cfg_ok,
   input  wire logic                  monitor_en,
   input  wire logic [15:0]           in_pins,
   input  wire logic [15:0]           master_out,
   input  wire fsm_pkg::fsm_dict_req_s dict_req,
   output fsm_pkg::fsm_dict_rsp_s     dict_rsp,
   output fsm_pkg::fsm_state_e        cur_state,
   output logic                       ack,
   output logic                       trans_err,
   output fsm_pkg::fsm_gate_s         gate,
   output logic      [15:0]           dp_inputs,
   output logic      [15:0]           out_pins,
   output logic                       nv_we,
   output logic      [23:0]           nv_addr,
   output logic      [31:0]           nv_data
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      fsm_pkg::fsm_state_e    state;
      logic                   ack;
      logic                   err;
      fsm_pkg::fsm_gate_s     gate;
      logic [15:0]            in_s1;
      logic [15:0]            in_s2;
      logic [15:0]            dp_in;
      logic [15:0]            outp;
      logic [31:0]            nostore;
      logic                   rd_pend;
      logic                   rsp_valid;
      logic                   rsp_err;
      logic [31:0]            rsp_fixed;
      logic                   rsp_fix_sel;
   } fsm_top_s;
   fsm_top_s st_reg, st_next;

   logic        mem_we;
   logic [11:0] mem_addr;
   logic [31:0] mem_rdata;
   logic        nv_start;
   logic        nv_busy;
   logic [3:0]  area;
   logic        chan_area;
   logic        drive_ok;

   ////////////////////////////////////////////////////////////////////////
   // dictionary decode
   always_comb begin
      area      = dict_req.index[15:12];
      // legacy area aliases channel area onto the same storage
      chan_area = (area == fsm_pkg::FSM_IDX_CHAN[15:12]) ||
                  (area == fsm_pkg::FSM_IDX_LEGACY[15:12]);
      mem_addr  = {dict_req.index[fsm_pkg::FSM_CH_BITS-1:0],
                   dict_req.subindex};
      mem_we    = dict_req.valid && dict_req.write && chan_area &&
                  st_reg.gate.mbx_ok && !st_reg.gate.foe_only && !nv_busy;
      nv_start  = mem_we && (st_reg.nostore != fsm_pkg::FSM_NOSTORE_KEY);
      drive_ok  = (st_reg.state == fsm_pkg::FSM_OP) ||
                  (st_reg.state == fsm_pkg::FSM_STATE_ALIAS_A && !monitor_en);
   end

   ////////////////////////////////////////////////////////////////////////
   // state machine and traffic gating
   always_comb begin
      st_next           = st_reg;
      st_next.ack       = 1'b0;
      st_next.err       = 1'b0;
      st_next.rsp_valid = 1'b0;
      st_next.rsp_err   = 1'b0;
      st_next.rd_pend   = 1'b0;
      st_next.in_s1     = in_pins;
      st_next.in_s2     = st_reg.in_s1;
      if (req_valid) begin
         case (st_reg.state)
            fsm_pkg::FSM_INIT: begin
               if (req_state == fsm_pkg::FSM_PREOP) begin
                  if (mbx_cfg_ok) begin
                     st_next.state = fsm_pkg::FSM_PREOP;
                     st_next.ack   = 1'b1;
                  end else begin
                     st_next.err = 1'b1;
                  end
               end else if (req_state == fsm_pkg::FSM_BOOT) begin
                  st_next.state = fsm_pkg::FSM_BOOT;
                  st_next.ack   = 1'b1;
               end else if (req_state == fsm_pkg::FSM_INIT) begin
                  st_next.ack = 1'b1;
               end else begin
                  st_next.err = 1'b1;
               end
            end
            fsm_pkg::FSM_PREOP: begin
               if (req_state == fsm_pkg::FSM_STATE_ALIAS_A) begin
                  if (pd_cfg_ok && (!dc_used || dc_cfg_ok)) begin
                     st_next.state = fsm_pkg::FSM_STATE_ALIAS_A;
                     st_next.dp_in = st_reg.in_s2;
                     st_next.ack   = 1'b1;
                  end else begin
                     st_next.err = 1'b1;
                  end
               end else if (req_state == fsm_pkg::FSM_INIT ||
                            req_state == fsm_pkg::FSM_PREOP) begin
                  st_next.state = req_state;
                  st_next.ack   = 1'b1;
               end else begin
                  st_next.err = 1'b1;
               end
            end
            fsm_pkg::FSM_STATE_ALIAS_A, fsm_pkg::FSM_OP: begin
               if (req_state == fsm_pkg::FSM_BOOT) begin
                  st_next.err = 1'b1;
               end else begin
                  // op reached only via state_alias_a; master supplies outputs
                  st_next.state = req_state;
                  st_next.ack   = 1'b1;
               end
            end
            fsm_pkg::FSM_BOOT: begin
               if (req_state == fsm_pkg::FSM_INIT ||
                   req_state == fsm_pkg::FSM_BOOT) begin
                  st_next.state = req_state;
                  st_next.ack   = 1'b1;
               end else begin
                  st_next.err = 1'b1;
               end
            end
            default: begin
               st_next.state = fsm_pkg::FSM_INIT;
            end
         endcase
      end
      case (st_next.state)
         fsm_pkg::FSM_INIT: st_next.gate = '0;
         fsm_pkg::FSM_PREOP: st_next.gate = '{1'b1, 1'b0, 1'b0};
         fsm_pkg::FSM_STATE_ALIAS_A,
         fsm_pkg::FSM_OP: st_next.gate = '{1'b1, 1'b1, 1'b0};
         fsm_pkg::FSM_BOOT: st_next.gate = '{1'b1, 1'b0, 1'b1};
         default: st_next.gate = '0;
      endcase
      if (st_reg.state == fsm_pkg::FSM_STATE_ALIAS_A ||
          st_reg.state == fsm_pkg::FSM_OP) begin
         st_next.dp_in = st_reg.in_s2;
      end
      if (drive_ok) begin
         st_next.outp = master_out;
      end else begin
         st_next.outp = fsm_pkg::FSM_SAFE_OUT;
      end
      // dictionary access
      if (dict_req.valid) begin
         st_next.rsp_fix_sel = 1'b1;
         st_next.rsp_fixed   = 32'h0000_0000;
         if (!st_reg.gate.mbx_ok || st_reg.gate.foe_only) begin
            st_next.rsp_valid = 1'b1;
            st_next.rsp_err   = 1'b1;
         end else if (dict_req.index == fsm_pkg::FSM_IDX_NOSTORE) begin
            if (dict_req.write) begin
               st_next.nostore = dict_req.wdata;
            end
            st_next.rsp_fixed = st_reg.nostore;
            st_next.rsp_valid = 1'b1;
         end else if (chan_area) begin
            if (dict_req.write) begin
               st_next.rsp_valid = 1'b1;
               st_next.rsp_err   = nv_busy;
            end else begin
               st_next.rd_pend     = 1'b1;
               st_next.rsp_fix_sel = 1'b0;
            end
         end else if (area == fsm_pkg::FSM_IDX_INPUT[15:12]) begin
            st_next.rsp_fixed = {16'h0000, st_reg.dp_in};
            st_next.rsp_valid = 1'b1;
            st_next.rsp_err   = dict_req.write;
         end else if (area == fsm_pkg::FSM_IDX_OUTPUT[15:12]) begin
            st_next.rsp_fixed = {16'h0000, master_out};
            st_next.rsp_valid = 1'b1;
            st_next.rsp_err   = dict_req.write;
         end else if (area == fsm_pkg::FSM_IDX_IDENT[15:12]) begin
            st_next.rsp_fixed = {dict_req.index, 8'h00, dict_req.subindex};
            st_next.rsp_valid = 1'b1;
            st_next.rsp_err   = dict_req.write;
         end else begin
            st_next.rsp_valid = 1'b1;
            st_next.rsp_err   = 1'b1;
         end
      end
      if (st_reg.rd_pend) begin
         st_next.rsp_valid = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   fsm_mem u_mem (
      .clk   (clk),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (dict_req.wdata),
      .rdata (mem_rdata)
   );

   fsm_nvcommit u_nv (
      .clk     (clk),
      .rst     (rst),
      .start   (nv_start),
      .addr    ({dict_req.index[11:0], 4'h0, dict_req.subindex}),
      .data    (dict_req.wdata),
      .nv_we   (nv_we),
      .nv_addr (nv_addr),
      .nv_data (nv_data),
      .busy    (nv_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   assign cur_state      = st_reg.state;
   assign ack            = st_reg.ack;
   assign trans_err      = st_reg.err;
   assign gate           = st_reg.gate;
   assign dp_inputs      = st_reg.dp_in;
   assign out_pins       = st_reg.outp;
   assign dict_rsp.valid = st_reg.rsp_valid;
   assign dict_rsp.error = st_reg.rsp_err;
   assign dict_rsp.rdata = st_reg.rsp_fix_sel ? st_reg.rsp_fixed : mem_rdata;
endmodule : fsm_node
`default_nettype wire

// ==== fsm_node_asserts.sv ====
// Purpose: port checker for the node state machine
// Assumes: one clock, sync active-high reset
// Notes:   bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module fsm_node_asserts (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   req_valid,
   input wire fsm_pkg::fsm_state_e    req_state,
   input wire logic                   mbx_cfg_ok,
   input wire logic                   pd_cfg_ok,
   input wire logic                   dc_used,
   input wire logic                   dc_cfg_ok,
   input wire logic                   monitor_en,
   input wire logic [15:0]            in_pins,
   input wire logic [15:0]            master_out,
   input wire fsm_pkg::fsm_dict_req_s dict_req,
   input wire fsm_pkg::fsm_dict_rsp_s dict_rsp,
   input wire fsm_pkg::fsm_state_e    cur_state,
   input wire logic                   trans_err,
   input wire fsm_pkg::fsm_gate_s     gate,
   input wire logic [15:0]            dp_inputs,
   input wire logic [15:0]            out_pins
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   reset_to_init_a: assert property (disable iff (1'b0)
      rst |=> cur_state == fsm_pkg::FSM_INIT) else $error("not init");
   init_gate_a: assert property (cur_state == fsm_pkg::FSM_INIT
      |-> !gate.mbx_ok && !gate.pd_ok) else $error("init gate open");
   preop_gate_a: assert property (cur_state == fsm_pkg::FSM_PREOP
      |-> gate.mbx_ok && !gate.pd_ok) else $error("preop gate wrong");
   boot_gate_a: assert property (cur_state == fsm_pkg::FSM_BOOT
      |-> gate.foe_only && !gate.pd_ok) else $error("boot gate wrong");
   boot_entry_a: assert property ($changed(cur_state) &&
      cur_state == fsm_pkg::FSM_BOOT |-> $past(cur_state) ==
      fsm_pkg::FSM_INIT) else $error("boot not from init");
   mbx_check_a: assert property (req_valid && !mbx_cfg_ok &&
      cur_state == fsm_pkg::FSM_INIT && req_state == fsm_pkg::FSM_PREOP
      |=> trans_err && cur_state == fsm_pkg::FSM_INIT)
      else $error("bad mailbox accepted");
   pd_check_a: assert property (req_valid &&
      cur_state == fsm_pkg::FSM_PREOP && req_state == fsm_pkg::FSM_STATE_ALIAS_A
      && (!pd_cfg_ok || (dc_used && !dc_cfg_ok))
      |=> trans_err && cur_state == fsm_pkg::FSM_PREOP)
      else $error("bad process setup accepted");
   safe_out_a: assert property ((cur_state ==
      fsm_pkg::FSM_STATE_ALIAS_A && monitor_en) [*2]
      |-> out_pins == fsm_pkg::FSM_SAFE_OUT) else $error("outputs unsafe");
   op_out_a: assert property ((cur_state == fsm_pkg::FSM_OP) [*2]
      |-> out_pins == $past(master_out)) else $error("outputs not copied");
   in_refresh_a: assert property ((cur_state ==
      fsm_pkg::FSM_STATE_ALIAS_A && $stable(in_pins)) [*4]
      |-> dp_inputs == in_pins) else $error("inputs stale");
   init_dict_a: assert property (dict_req.valid &&
      cur_state == fsm_pkg::FSM_INIT |=> dict_rsp.valid && dict_rsp.error)
      else $error("init dictionary served");
   cover_op_c: cover property (cur_state == fsm_pkg::FSM_OP);
   cover_boot_c: cover property (cur_state == fsm_pkg::FSM_BOOT);
   cover_err_c: cover property (trans_err);
endmodule : fsm_node_asserts
`default_nettype wire

// ==== fsm_master_model.sv ====
// Purpose: network master side: config levels and output data
// Assumes: bench sets the steps between requests
// Notes:   changes on falling edge
`timescale 1ns/10ps
`default_nettype none
module fsm_master_model (
   input  wire logic        clk,
   input  wire logic [1:0]  cfg_step,
   input  wire logic        dc_use,
   input  wire logic        dc_fault,
   input  wire logic [15:0] out_data,
   output logic             mbx_cfg_ok,
   output logic             pd_cfg_ok,
   output logic             dc_used,
   output logic             dc_cfg_ok,
   output logic      [15:0] master_out
);
   always @(negedge clk) begin
      mbx_cfg_ok <= cfg_step != 2'h0;
      pd_cfg_ok  <= cfg_step[1];
      dc_used    <= dc_use;
      dc_cfg_ok  <= ~dc_fault;
      master_out <= out_data;
   end
endmodule : fsm_master_model
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the node state machine
// Assumes: reference model tracks state from the levels it sets
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
bind fsm_node fsm_node_asserts i_chk (.clk, .rst, .req_valid, .req_state,
   .mbx_cfg_ok, .pd_cfg_ok, .dc_used, .dc_cfg_ok, .monitor_en, .in_pins,
   .master_out, .dict_req, .dict_rsp, .cur_state, .trans_err, .gate,
   .dp_inputs, .out_pins);
module tb;
   logic                   clk, rst, req_valid, monitor_en, ack, trans_err;
   logic                   dc_use, dc_fault, nv_we;
   logic                   mbx_cfg_ok, pd_cfg_ok, dc_used, dc_cfg_ok;
   logic [1:0]             cfg_step;
   logic [15:0]            in_pins, out_data, master_out, dp_inputs, out_pins;
   logic [23:0]            nv_addr;
   logic [31:0]            nv_data, seed, r, d;
   fsm_pkg::fsm_state_e    req_state, cur_state;
   fsm_pkg::fsm_dict_req_s dict_req;
   fsm_pkg::fsm_dict_rsp_s dict_rsp;
   fsm_pkg::fsm_gate_s     gate;
   int                     fail_count, check_count, cyc, nv_cnt, n0, ex;
   fsm_node i_fsm_node (.clk, .rst, .req_valid, .req_state, .mbx_cfg_ok,
      .pd_cfg_ok, .dc_used, .dc_cfg_ok, .monitor_en, .in_pins, .master_out,
      .dict_req, .dict_rsp, .cur_state, .ack, .trans_err, .gate, .dp_inputs,
      .out_pins, .nv_we, .nv_addr, .nv_data);
   fsm_master_model i_fsm_master_model (.clk, .cfg_step, .dc_use, .dc_fault,
      .out_data, .mbx_cfg_ok, .pd_cfg_ok, .dc_used, .dc_cfg_ok, .master_out);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic bit legal(int c, int q);
      if (c == q) return 1;
      case (c)
         0: return (q == 1 && cfg_step != 0) || q == 4;
         1: return q == 0 || (q == 2 && cfg_step[1] && !(dc_use && dc_fault));
         2, 3: return q != 4;
         default: return q == 0;
      endcase
   endfunction : legal
   task automatic chk_val(logic [31:0] g, logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t value %h expected %h", $time, g, e);
      end
   endtask : chk_val
   task automatic chk_st(fsm_pkg::fsm_state_e g, fsm_pkg::fsm_state_e e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t state %0d expected %0d", $time, g, e);
      end
   endtask : chk_st
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic req(int q);
      bit       ok;
      bit [2:0] m, e;
      @(negedge clk);
      ok = legal(ex, q);
      req_valid = 1'b1;
      req_state = fsm_pkg::fsm_state_e'(q);
      @(negedge clk);
      req_valid = 1'b0;
      chk_val(32'({ack, trans_err}), ok ? 32'h2 : 32'h1);
      if (ok) ex = q;
      chk_st(cur_state, fsm_pkg::fsm_state_e'(ex));
      m = (ex == 4) ? 3'h3 : 3'h7;
      e = {ex inside {1, 2, 3}, ex inside {2, 3}, ex == 4};
      chk_val(32'(gate & m), 32'(e & m));
   endtask : req
   task automatic dict(bit w, logic [15:0] ix, logic [31:0] wd, bit er,
                       logic [31:0] rd);
      int n;
      @(negedge clk);
      dict_req = '{1'b1, w, ix, 8'h02, wd};
      @(negedge clk);
      dict_req.valid = 1'b0;
      n = 0;
      while (dict_rsp.valid !== 1'b1 && n < 3) begin
         @(negedge clk);
         n++;
      end
      chk_val(32'(dict_rsp.error), 32'(er));
      if (!w && !er) chk_val(dict_rsp.rdata, rd);
      repeat (8) @(negedge clk);
   endtask : dict
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (nv_we === 1'b1) nv_cnt++;
      if (cyc == 6000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      seed = 32'h47;
      {rst, monitor_en} = 2'h3;
      {req_valid, dc_use, dc_fault, cfg_step} = '0;
      {in_pins, out_data} = '0;
      req_state = fsm_pkg::FSM_INIT;
      dict_req = '0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      chk_st(cur_state, fsm_pkg::FSM_INIT);
      dict(0, 16'h8000, 0, 1, 0);
      req(3);
      req(1);
      req(4);
      req(1);
      req(0);
      cfg_step = 2'h1;
      req(1);
      req(4);
      req(3);
      dict(1, 16'h1000, rnd(), 1, 0);
      dict(0, 16'h3000, 0, 1, 0);
      d = rnd();
      n0 = nv_cnt;
      dict(1, 16'h8003, d, 0, 0);
      chk_val(32'(nv_cnt - n0), 32'h1);
      chk_val(nv_data, d);
      chk_val(32'(nv_addr), 32'h0000_3002);
      dict(0, 16'h4003, 0, 0, d);
      dict(1, 16'hf008, fsm_pkg::FSM_NOSTORE_KEY, 0, 0);
      n0 = nv_cnt;
      dict(1, 16'h8004, rnd(), 0, 0);
      chk_val(32'(nv_cnt - n0), 32'h0);
      dict(0, 16'hf008, 0, 0, fsm_pkg::FSM_NOSTORE_KEY);
      dict(1, 16'hf008, 32'h0, 0, 0);
      n0 = nv_cnt;
      dict(1, 16'h8004, rnd(), 0, 0);
      chk_val(32'(nv_cnt - n0), 32'h1);
      {dc_use, dc_fault} = 2'h3;
      req(2);
      dc_fault = 1'b0;
      req(2);
      cfg_step = 2'h2;
      r = rnd();
      in_pins = r[15:0];
      out_data = r[31:16];
      repeat (4) @(negedge clk);
      req(2);
      chk_val(32'(dp_inputs), 32'(in_pins));
      chk_val(32'(out_pins), 32'h0);
      monitor_en = 1'b0;
      repeat (3) @(negedge clk);
      chk_val(32'(out_pins), 32'(out_data));
      monitor_en = 1'b1;
      req(3);
      repeat (8) begin
         r = rnd();
         out_data = r[15:0];
         in_pins = r[31:16];
         repeat (4) @(negedge clk);
         chk_val(32'(out_pins), 32'(out_data));
         chk_val(32'(dp_inputs), 32'(in_pins));
      end
      dict(0, 16'h6000, 0, 0, {16'h0000, in_pins});
      dict(1, 16'h7000, rnd(), 1, 0);
      repeat (40) begin
         r = rnd();
         {dc_fault, cfg_step} = r[2:0];
         req(int'(r[6:4]) % 5);
      end
      complete_run();
   end
endmodule : tb
`default_nettype wire
